/* core/lcsc_charger.sv */
// Charger state sequencer with timers, status flags and register port.
// Functional notes
// - Min-system-voltage status bit mirrors loop; change raises maskable interrupt.
// - Supplement disables min-system-voltage loop; it returns when supplement ends.
// - Die-temperature status bit mirrors current reduction; change raises maskable interrupt.
// - Four-bit state code reported; any change raises maskable interrupt.
// - Stay off while input invalid, charger disabled, or battery fresh.
// - Input invalid keeps battery connected to system rail.
// - Enable bit zero disables charger; connection follows input validity.
// - Fresh battery stays disconnected and uncharged until it drops by restart margin.
// - Below prequalification threshold, charge at reduced current; threshold field three bits.
// - Prequalification timed from first entry; fault after thirty minutes.
// - Above prequalification threshold, enter constant-current charge; six-bit current field.
// - Reaching target voltage enters constant-voltage charge, holding target.
// - In constant voltage, current below termination enters top-off; two-bit field.
// - Safety timer starts entering constant current from non-fast state; runs across fast states.
// - Safety timer three, five or seven hours; code zero disables it.
// - Safety timer expiry in fast charge moves to fast-charge timer fault.
// - Safety timer pauses on low constant current or supplement; pause shown.
// - Top-off holds target voltage, starts top-off timer; expiry enters done.
// - Top-off time zero to thirty-five minutes; zero finishes immediately at termination.
// - Done keeps battery disconnected; restart when battery falls by restart margin.
// - Timer faults deliver no current and keep battery disconnected.
// - Timer fault left only by toggling enable or reconnecting input.
// - Temperature fault pauses timers; prequalification resumes, others restart from zero.
`timescale 1ns/1ps
`include "lcsc_defines.svh"

module lcsc_charger
  import lcsc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `LCSC_TICK_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [`LCSC_AW-1:0] addr_i,
  input wire logic [`LCSC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire lcsc_sense_t sense_i,
  output logic [`LCSC_DW-1:0] rdata_o,
  output logic irq_o,
  output lcsc_cfg_t cfg_o,
  output lcsc_drive_t drive_o
);

  localparam int unsigned NS = $bits(lcsc_sense_t);

  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  lcsc_sense_t sn;

  // Every comparator level crosses in through two flops before any logic looks at it.
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge clk_sys_i)
      begin
        if (srst_i)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= sense_i[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  assign sn = lcsc_sense_t'(sync2_r);

  logic [`LCSC_DW-1:0] irq_flag_r;
  logic [`LCSC_DW-1:0] irq_mask_r;
  logic [`LCSC_DW-1:0] cfg_b_r;
  logic [`LCSC_DW-1:0] cfg_c_r;
  logic [`LCSC_DW-1:0] cfg_d_r;
  logic [`LCSC_DW-1:0] cfg_e_r;
  logic [`LCSC_DW-1:0] cfg_cv_r;

  wire wr_irq = wr_i && (addr_i == `LCSC_ADDR_IRQ);
  wire wr_mask = wr_i && (addr_i == `LCSC_ADDR_MASK);
  wire wr_cfg_b = wr_i && (addr_i == `LCSC_ADDR_CFG_B);
  wire wr_cfg_c = wr_i && (addr_i == `LCSC_ADDR_CFG_C);
  wire wr_cfg_d = wr_i && (addr_i == `LCSC_ADDR_CFG_D);
  wire wr_cfg_e = wr_i && (addr_i == `LCSC_ADDR_CFG_E);
  wire wr_cfg_cv = wr_i && (addr_i == `LCSC_ADDR_CFG_CV);

  wire charger_enable_bit = cfg_b_r[0];
  wire precharge_current_sel = cfg_b_r[1];
  wire [2:0] precharge_threshold_sel = cfg_c_r[2:0];
  wire [1:0] term_level_sel = cfg_c_r[4:3];
  wire [2:0] topoff_time_sel = cfg_c_r[7:5];
  wire [2:0] die_temp_limit_sel = cfg_d_r[2:0];
  wire [5:0] fast_current_sel = cfg_e_r[5:0];
  wire [1:0] safety_timer_sel = cfg_e_r[7:6];
  wire [5:0] cv_target_sel = cfg_cv_r[5:0];

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      irq_mask_r <= `LCSC_RST_MASK;
      cfg_b_r <= `LCSC_RST_CFG_B;
      cfg_c_r <= `LCSC_RST_CFG_C;
      cfg_d_r <= `LCSC_RST_CFG_D;
      cfg_e_r <= `LCSC_RST_CFG_E;
      cfg_cv_r <= `LCSC_RST_CFG_CV;
    end
    else
    begin
      if (wr_mask)
        irq_mask_r <= wdata_i;
      if (wr_cfg_b)
        cfg_b_r <= wdata_i;
      if (wr_cfg_c)
        cfg_c_r <= wdata_i;
      if (wr_cfg_d)
        cfg_d_r <= wdata_i;
      if (wr_cfg_e)
        cfg_e_r <= wdata_i;
      if (wr_cfg_cv)
        cfg_cv_r <= wdata_i;
    end
  end

  // One-second tick shared by all timers; the divider is a parameter so simulation can shorten it.
  logic [31:0] tick_cnt_r;
  wire tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      tick_cnt_r <= 32'h0000_0000;
    else if (tick)
      tick_cnt_r <= 32'h0000_0000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end

  lcsc_state_t state_r;
  lcsc_state_t state_nxt;
  lcsc_state_t resume_r;
  logic [`LCSC_TW-1:0] pq_sec_r;
  logic [`LCSC_TW-1:0] fc_sec_r;
  logic [`LCSC_TW-1:0] to_sec_r;

  wire [`LCSC_TW-1:0] fc_limit = `LCSC_TW'((`LCSC_FC_BASE_HR + `LCSC_FC_STEP_HR * (safety_timer_sel - 2'd1))
                                           * `LCSC_SEC_PER_HR);
  wire fc_enabled = (safety_timer_sel != 2'b00);
  wire [`LCSC_TW-1:0] to_limit = `LCSC_TW'(topoff_time_sel * `LCSC_TO_STEP_MIN * `LCSC_SEC_PER_MIN);
  wire [`LCSC_TW-1:0] pq_limit = `LCSC_TW'(`LCSC_PQ_TIME_MIN * `LCSC_SEC_PER_MIN);

  wire in_fast = (state_r == ST_CC) || (state_r == ST_CV);
  wire pq_expired = (pq_sec_r >= pq_limit);
  wire fc_expired = fc_enabled && (fc_sec_r >= fc_limit);
  wire to_expired = (to_sec_r >= to_limit);
  // pause on low current or supplement
  wire fc_paused = in_fast && (((state_r == ST_CC) && sn.curr_below_fifth) || sn.supplement);
  wire charge_allowed = sn.input_valid && charger_enable_bit;
  wire state_chargeable = (state_r == ST_PREQ) || in_fast || (state_r == ST_TOPOFF) || (state_r == ST_DONE);
  wire entering_fast = ((state_nxt == ST_CC) || (state_nxt == ST_CV)) && !in_fast;

  always_comb
  begin
    state_nxt = state_r;
    // off whenever input invalid or disabled
    // dropping enable or input is the only timer-fault exit
    if (!charge_allowed)
      state_nxt = ST_OFF;
    else if (sn.battery_node_temp_fault && state_chargeable)
      state_nxt = ST_TEMP_FAULT;
    else
    begin
      case (state_r)
        ST_OFF:
          // fresh battery waits for restart margin
          if (sn.battery_node_below_restart)
            state_nxt = sn.battery_node_below_pq ? ST_PREQ : ST_CC;
        ST_PREQ:
          if (pq_expired)
            state_nxt = ST_PQ_FAULT;
          else if (!sn.battery_node_below_pq)
            state_nxt = ST_CC;
        ST_CC:
          if (fc_expired)
            state_nxt = ST_FC_FAULT;
          else if (sn.battery_node_below_pq)
            state_nxt = ST_PREQ;
          else if (sn.battery_node_at_cv)
            state_nxt = ST_CV;
        ST_CV:
          if (fc_expired)
            state_nxt = ST_FC_FAULT;
          // zero top-off goes straight to done
          else if (sn.curr_below_term)
            state_nxt = (to_limit == `LCSC_TW'(0)) ? ST_DONE : ST_TOPOFF;
        ST_TOPOFF:
          if (to_expired)
            state_nxt = ST_DONE;
        ST_DONE:
          if (sn.battery_node_below_restart)
            state_nxt = sn.battery_node_below_pq ? ST_PREQ : ST_CC;
        ST_TEMP_FAULT:
          if (!sn.battery_node_temp_fault)
            state_nxt = resume_r;
        ST_PQ_FAULT,
        ST_FC_FAULT:
          state_nxt = state_r;
        default:
          state_nxt = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state_r <= ST_OFF;
      resume_r <= ST_OFF;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt == ST_TEMP_FAULT && state_r != ST_TEMP_FAULT)
        resume_r <= state_r;
    end
  end

  // Prequalification timer: cleared only on entry from ST_OFF or ST_DONE, so it resumes after a temperature fault.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      pq_sec_r <= `LCSC_TW'(0);
    else if (state_nxt == ST_PREQ && (state_r == ST_OFF || state_r == ST_DONE))
      pq_sec_r <= `LCSC_TW'(0);
    else if (state_r == ST_PREQ && tick && !pq_expired)
      pq_sec_r <= pq_sec_r + `LCSC_TW'(1);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      fc_sec_r <= `LCSC_TW'(0);
    // start on entry into fast charge
    else if (entering_fast)
      fc_sec_r <= `LCSC_TW'(0);
    else if (in_fast && tick && !fc_paused && !fc_expired)
      fc_sec_r <= fc_sec_r + `LCSC_TW'(1);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      to_sec_r <= `LCSC_TW'(0);
    else if (state_nxt == ST_TOPOFF && state_r != ST_TOPOFF)
      to_sec_r <= `LCSC_TW'(0);
    else if (state_r == ST_TOPOFF && tick && !to_expired)
      to_sec_r <= to_sec_r + `LCSC_TW'(1);
  end

  function automatic logic [3:0] state_code(input lcsc_state_t s);
    case (s)
      ST_PREQ: state_code = `LCSC_CODE_PREQ;
      ST_CC: state_code = `LCSC_CODE_CC;
      ST_CV: state_code = `LCSC_CODE_CV;
      ST_TOPOFF: state_code = `LCSC_CODE_TOPOFF;
      ST_DONE: state_code = `LCSC_CODE_DONE;
      ST_PQ_FAULT: state_code = `LCSC_CODE_PQ_FAULT;
      ST_FC_FAULT: state_code = `LCSC_CODE_FC_FAULT;
      ST_TEMP_FAULT: state_code = `LCSC_CODE_TEMP_FAULT;
      default: state_code = `LCSC_CODE_OFF;
    endcase
  endfunction

  wire [3:0] charger_state_code = state_code(state_r);
  wire safety_timer_paused = fc_paused;

  // Status images one cycle old, used only for change detection.
  logic sysv_prev_r;
  logic die_prev_r;
  logic [3:0] code_prev_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      sysv_prev_r <= 1'b0;
      die_prev_r <= 1'b0;
      code_prev_r <= `LCSC_CODE_OFF;
    end
    else
    begin
      sysv_prev_r <= sn.min_sysv_loop_active;
      die_prev_r <= sn.die_temp_loop_active;
      code_prev_r <= charger_state_code;
    end
  end

  wire min_sysv_change_irq = sn.min_sysv_loop_active ^ sysv_prev_r;
  wire die_temp_change_irq = sn.die_temp_loop_active ^ die_prev_r;
  wire charger_state_irq = (charger_state_code != code_prev_r);

  wire [`LCSC_DW-1:0] irq_set = {5'h00, charger_state_irq, die_temp_change_irq, min_sysv_change_irq};
  wire [`LCSC_DW-1:0] irq_clr = wr_irq ? wdata_i : 8'h00;

  // Write-one-to-clear; a new event in the clearing cycle wins so it is never lost.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      irq_flag_r <= 8'h00;
    else
      irq_flag_r <= (irq_flag_r & ~irq_clr) | irq_set;
  end

  wire [`LCSC_DW-1:0] status_a = {6'h00, sn.die_temp_loop_active, sn.min_sysv_loop_active};
  wire [`LCSC_DW-1:0] status_b = {3'h0, safety_timer_paused, charger_state_code};

  wire [`LCSC_DW-1:0] rd_mux =
    (addr_i == `LCSC_ADDR_IRQ) ? irq_flag_r :
    (addr_i == `LCSC_ADDR_MASK) ? irq_mask_r :
    (addr_i == `LCSC_ADDR_STAT_A) ? status_a :
    (addr_i == `LCSC_ADDR_STAT_B) ? status_b :
    (addr_i == `LCSC_ADDR_CFG_B) ? cfg_b_r :
    (addr_i == `LCSC_ADDR_CFG_C) ? cfg_c_r :
    (addr_i == `LCSC_ADDR_CFG_D) ? cfg_d_r :
    (addr_i == `LCSC_ADDR_CFG_E) ? cfg_e_r :
    (addr_i == `LCSC_ADDR_CFG_CV) ? cfg_cv_r : 8'h00;

  // Power-path commands decoded from the state and the synchronized sense levels.
  wire charging = (state_r == ST_PREQ) || in_fast || (state_r == ST_TOPOFF);
  lcsc_drive_t drive_nxt;
  assign drive_nxt.charge_on = charging;
  assign drive_nxt.cc_mode = (state_r == ST_PREQ) || (state_r == ST_CC);
  assign drive_nxt.cv_hold = (state_r == ST_CV) || (state_r == ST_TOPOFF);
  // invalid input keeps battery on the rail
  assign drive_nxt.battery_node_connect = !sn.input_valid || (charging && sn.supplement);
  assign drive_nxt.min_sysv_loop_en = !sn.supplement;

  lcsc_cfg_t cfg_nxt;
  assign cfg_nxt = '{precharge_current_sel, precharge_threshold_sel, term_level_sel,
                     die_temp_limit_sel, fast_current_sel, cv_target_sel};

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
      cfg_o <= '0;
      drive_o <= '0;
    end
    else
    begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      irq_o <= |(irq_flag_r & irq_mask_r);
      cfg_o <= cfg_nxt;
      drive_o <= drive_nxt;
    end
  end

endmodule

/* core/lcsc_defines.svh */
// Offsets, field positions, reset values, state codes and timing figures of the charger sequencer.
`ifndef LCSC_DEFINES_SVH
`define LCSC_DEFINES_SVH

`define LCSC_AW 8
`define LCSC_DW 8

`define LCSC_ADDR_IRQ 8'h00
`define LCSC_ADDR_MASK 8'h01
`define LCSC_ADDR_STAT_A 8'h02
`define LCSC_ADDR_STAT_B 8'h03
`define LCSC_ADDR_CFG_B 8'h04
`define LCSC_ADDR_CFG_C 8'h05
`define LCSC_ADDR_CFG_D 8'h06
`define LCSC_ADDR_CFG_E 8'h07
`define LCSC_ADDR_CFG_CV 8'h08

`define LCSC_IRQ_SYSV_BIT 0
`define LCSC_IRQ_DIE_BIT 1
`define LCSC_IRQ_STATE_BIT 2
`define LCSC_STB_PAUSED_BIT 4

`define LCSC_RST_MASK 8'h00
`define LCSC_RST_CFG_B 8'h00
`define LCSC_RST_CFG_C 8'h00
`define LCSC_RST_CFG_D 8'h00
`define LCSC_RST_CFG_E 8'h00
`define LCSC_RST_CFG_CV 8'h00

`define LCSC_CODE_OFF 4'h0
`define LCSC_CODE_PREQ 4'h1
`define LCSC_CODE_CC 4'h2
`define LCSC_CODE_CV 4'h3
`define LCSC_CODE_TOPOFF 4'h4
`define LCSC_CODE_DONE 4'h5
`define LCSC_CODE_PQ_FAULT 4'h6
`define LCSC_CODE_FC_FAULT 4'h7
`define LCSC_CODE_TEMP_FAULT 4'h8

`define LCSC_CLK_PERIOD_NS 25
`define LCSC_TICK_NS 1000000000
`define LCSC_TICK_CYCLES (`LCSC_TICK_NS / `LCSC_CLK_PERIOD_NS)
`define LCSC_SEC_PER_MIN 60
`define LCSC_SEC_PER_HR 3600
`define LCSC_PQ_TIME_MIN 30
`define LCSC_FC_BASE_HR 3
`define LCSC_FC_STEP_HR 2
`define LCSC_TO_STEP_MIN 5
`define LCSC_TW 15

`endif

/* core/lcsc_pkg.sv */
// Types shared by the charger sequencer.
package lcsc_pkg;

  typedef enum logic [3:0] {
    ST_OFF,
    ST_PREQ,
    ST_CC,
    ST_CV,
    ST_TOPOFF,
    ST_DONE,
    ST_PQ_FAULT,
    ST_FC_FAULT,
    ST_TEMP_FAULT
  } lcsc_state_t;

  // Qualified comparator levels from the analog side, all asynchronous to clk_sys_i.
  typedef struct packed {
    logic input_valid;
    logic battery_node_below_pq;
    logic battery_node_at_cv;
    logic battery_node_below_restart;
    logic curr_below_term;
    logic curr_below_fifth;
    logic supplement;
    logic min_sysv_loop_active;
    logic die_temp_loop_active;
    logic battery_node_temp_fault;
  } lcsc_sense_t;

  // Setpoints handed to the analog loops.
  typedef struct packed {
    logic precharge_current_sel;
    logic [2:0] precharge_threshold_sel;
    logic [1:0] term_level_sel;
    logic [2:0] die_temp_limit_sel;
    logic [5:0] fast_current_sel;
    logic [5:0] cv_target_sel;
  } lcsc_cfg_t;

  // Drive commands to the power path.
  typedef struct packed {
    logic charge_on;
    logic cc_mode;
    logic cv_hold;
    logic battery_node_connect;
    logic min_sysv_loop_en;
  } lcsc_drive_t;

endpackage

/* tb/lcsc_charger_props.sv */
// Port-level assertions for the charger sequencer, bound to its top module.
`timescale 1ns/1ps
`include "lcsc_defines.svh"

module lcsc_charger_props
  import lcsc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `LCSC_TICK_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [`LCSC_AW-1:0] addr_i,
  input wire logic [`LCSC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire lcsc_sense_t sense_i,
  input wire logic [`LCSC_DW-1:0] rdata_o,
  input wire logic irq_o,
  input wire lcsc_cfg_t cfg_o,
  input wire lcsc_drive_t drive_o
);
  // Sense levels reach drive_o three or four edges late, so level checks wait until the pipe is refilled.
  logic [2:0] rel_cnt_r;
  logic [2:0] rel_cnt_nxt;
  logic [2:0] hold_cnt_r;
  logic [2:0] hold_cnt_nxt;
  logic [2:0] mask_r;
  logic [2:0] mask_nxt;
  lcsc_sense_t sense_r;
  wire settled = (rel_cnt_r == 3'h5);

  assign rel_cnt_nxt = settled ? rel_cnt_r : rel_cnt_r + 3'h1;
  assign hold_cnt_nxt = (sense_i != sense_r) ? 3'h0 : (hold_cnt_r == 3'h7) ? hold_cnt_r : hold_cnt_r + 3'h1;
  assign mask_nxt = (wr_i && addr_i == `LCSC_ADDR_MASK) ? wdata_i[2:0] : mask_r;

  always_ff @(posedge clk_sys_i)
  begin
    sense_r <= sense_i;
    rel_cnt_r <= srst_i ? 3'h0 : rel_cnt_nxt;
    hold_cnt_r <= srst_i ? 3'h0 : hold_cnt_nxt;
    mask_r <= srst_i ? 3'h0 : mask_nxt;
  end

  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  sequence supp_end_s;
    sense_i.supplement ##1 !sense_i.supplement;
  endsequence

  sequence supp_start_s;
    !sense_i.supplement ##1 sense_i.supplement;
  endsequence

  loop_back_a: assert property (settled ##0 supp_end_s |-> ##3 drive_o.min_sysv_loop_en)
    else $error("loop not restored after supplement");
  loop_drop_a: assert property (settled ##0 supp_start_s |-> ##3 !drive_o.min_sysv_loop_en)
    else $error("loop not overridden in supplement");
  invalid_conn_a: assert property (settled && !$past(sense_i.input_valid, 3) |-> drive_o.battery_node_connect)
    else $error("battery cut off with invalid input");
  invalid_off_a: assert property (settled && !$past(sense_i.input_valid, 4) |-> !drive_o.charge_on)
    else $error("charging with invalid input");
  disable_off_a: assert property (wr_i && addr_i == `LCSC_ADDR_CFG_B && !wdata_i[0] |-> ##3 !drive_o.charge_on)
    else $error("charging after disable");
  battery_node_cut_a: assert property (settled && $past(sense_i.input_valid, 3) && !$past(sense_i.supplement, 3)
    |-> !drive_o.battery_node_connect)
    else $error("battery connected with valid input");
  mask_quiet_a: assert property (mask_r == 3'h0 |=> !irq_o)
    else $error("interrupt with all sources masked");
  status_loop_a: assert property (settled && hold_cnt_r >= 3'h4 && rd_i && addr_i == `LCSC_ADDR_STAT_A |=>
    rdata_o == {6'h00, $past(sense_i.die_temp_loop_active), $past(sense_i.min_sysv_loop_active)})
    else $error("loop status read wrong");
  fast_sel_a: assert property (wr_i && addr_i == `LCSC_ADDR_CFG_E |-> ##2
    cfg_o.fast_current_sel == $past(wdata_i[5:0], 2))
    else $error("fast current setting not applied");
  pq_sel_a: assert property (wr_i && addr_i == `LCSC_ADDR_CFG_C |-> ##2
    {cfg_o.precharge_threshold_sel, cfg_o.term_level_sel} == {$past(wdata_i[2:0], 2), $past(wdata_i[4:3], 2)})
    else $error("prequal or termination setting not applied");
endmodule

bind lcsc_charger lcsc_charger_props #(.TICK_CYCLES(TICK_CYCLES)) lcsc_charger_props_i (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .sense_i(sense_i), .rdata_o(rdata_o), .irq_o(irq_o), .cfg_o(cfg_o), .drive_o(drive_o)
);

/* tb/test_lcsc_charger.sv */
// Self-checking bench for the charger sequencer with an expected-output model.
`timescale 1ns/1ps
`include "lcsc_defines.svh"

module test_lcsc_charger
  import lcsc_pkg::*;
;
  // A short tick keeps the half-hour and three-hour timers inside a short run.
  localparam int TK = 4;
  localparam int PQ_CYC = `LCSC_PQ_TIME_MIN * `LCSC_SEC_PER_MIN * TK;
  localparam int TO_CYC = `LCSC_TO_STEP_MIN * `LCSC_SEC_PER_MIN * TK;
  localparam int FC_CYC = `LCSC_FC_BASE_HR * `LCSC_SEC_PER_HR * TK;
  logic clk_sys_i;
  logic srst_i;
  logic wr_i;
  logic rd_i;
  logic irq_o;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic [7:0] got;
  logic [7:0] val [6];
  logic [7:0] regs [6] = '{`LCSC_ADDR_MASK, `LCSC_ADDR_CFG_B, `LCSC_ADDR_CFG_C,
    `LCSC_ADDR_CFG_D, `LCSC_ADDR_CFG_E, `LCSC_ADDR_CFG_CV};
  logic [7:0] keep [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  lcsc_sense_t sense_i;
  lcsc_sense_t sn;
  lcsc_cfg_t cfg_o;
  lcsc_drive_t drive_o;
  int error_cnt;
  int samples_checked;
  int seed;

  lcsc_charger #(.TICK_CYCLES(TK)) lcsc_charger_i (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .sense_i(sense_i), .rdata_o(rdata_o), .irq_o(irq_o), .cfg_o(cfg_o), .drive_o(drive_o)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h, expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_pin(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h, expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd(a, got);
    cmp_reg(got, e);
  endtask

  // The sense pipe and the state step need a few edges, so every change is given six.
  task automatic put();
    @(posedge clk_sys_i);
    sense_i <= sn;
    cyc(6);
  endtask

  task automatic check(input logic [3:0] st);
    logic chg;
    logic pau;
    lcsc_drive_t ed;
    chg = (st >= `LCSC_CODE_PREQ) && (st <= `LCSC_CODE_TOPOFF);
    pau = (st == `LCSC_CODE_CC && sn.curr_below_fifth) || ((st == `LCSC_CODE_CC || st == `LCSC_CODE_CV) && sn.supplement);
    ed.charge_on = chg;
    ed.cc_mode = (st == `LCSC_CODE_PREQ) || (st == `LCSC_CODE_CC);
    ed.cv_hold = (st == `LCSC_CODE_CV) || (st == `LCSC_CODE_TOPOFF);
    ed.battery_node_connect = !sn.input_valid || (chg && sn.supplement);
    ed.min_sysv_loop_en = !sn.supplement;
    rd(`LCSC_ADDR_STAT_B, got);
    cmp_reg(got, {3'h0, pau, st});
    cmp_pin({27'h0, drive_o}, {27'h0, ed});
  endtask

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    cyc(FC_CYC + PQ_CYC + 20000);
    error_cnt++;
    results();
  end

  initial
  begin
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    sn = '0;
    sense_i = '0;
    error_cnt = 0;
    samples_checked = 0;
    seed = 32'hc7a2;
    cyc(10);
    srst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd_chk(regs[i], 8'h00);
    rd_chk(`LCSC_ADDR_IRQ, 8'h00);
    wr(8'h1f, 8'hff);
    rd_chk(8'h1f, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      val[i] = 8'($random(seed));
      wr(regs[i], val[i]);
    end
    for (int i = 0; i < 6; i++)
      rd_chk(regs[i], val[i] & keep[i]);
    cmp_pin({11'h0, cfg_o}, {11'h0, val[1][1], val[2][2:0], val[2][4:3], val[3][2:0], val[4][5:0], val[5][5:0]});
    wr(`LCSC_ADDR_CFG_C, 8'h20);
    wr(`LCSC_ADDR_CFG_E, 8'h00);
    wr(`LCSC_ADDR_CFG_B, 8'h00);
    wr(`LCSC_ADDR_MASK, 8'h04);
    wr(`LCSC_ADDR_IRQ, 8'hff);
    sn.input_valid = 1'b1;
    put();
    wr(`LCSC_ADDR_CFG_B, 8'h01);
    cyc(4);
    check(`LCSC_CODE_OFF);
    sn.battery_node_below_restart = 1'b1;
    sn.battery_node_below_pq = 1'b1;
    put();
    check(`LCSC_CODE_PREQ);
    rd_chk(`LCSC_ADDR_IRQ, 8'h04);
    cmp_pin({31'h0, irq_o}, 32'h1);
    wr(`LCSC_ADDR_IRQ, 8'h04);
    cyc(2);
    cmp_pin({31'h0, irq_o}, 32'h0);
    sn.battery_node_below_pq = 1'b0;
    put();
    check(`LCSC_CODE_CC);
    sn.curr_below_fifth = 1'b1;
    put();
    check(`LCSC_CODE_CC);
    sn.curr_below_fifth = 1'b0;
    sn.supplement = 1'b1;
    put();
    check(`LCSC_CODE_CC);
    sn.supplement = 1'b0;
    sn.battery_node_at_cv = 1'b1;
    sn.battery_node_below_restart = 1'b0;
    put();
    check(`LCSC_CODE_CV);
    sn.curr_below_term = 1'b1;
    put();
    check(`LCSC_CODE_TOPOFF);
    cyc(TO_CYC - 100);
    check(`LCSC_CODE_TOPOFF);
    cyc(200);
    check(`LCSC_CODE_DONE);
    sn.battery_node_at_cv = 1'b0;
    sn.curr_below_term = 1'b0;
    put();
    check(`LCSC_CODE_DONE);
    sn.battery_node_below_restart = 1'b1;
    put();
    check(`LCSC_CODE_CC);
    wr(`LCSC_ADDR_CFG_C, 8'h00);
    sn.battery_node_at_cv = 1'b1;
    sn.battery_node_below_restart = 1'b0;
    put();
    sn.curr_below_term = 1'b1;
    put();
    check(`LCSC_CODE_DONE);
    sn = '0;
    sn.input_valid = 1'b1;
    sn.battery_node_below_restart = 1'b1;
    sn.battery_node_below_pq = 1'b1;
    put();
    check(`LCSC_CODE_PREQ);
    cyc(3000);
    sn.battery_node_temp_fault = 1'b1;
    put();
    check(`LCSC_CODE_TEMP_FAULT);
    cyc(2000);
    sn.battery_node_temp_fault = 1'b0;
    put();
    check(`LCSC_CODE_PREQ);
    cyc(PQ_CYC - 3200);
    check(`LCSC_CODE_PREQ);
    cyc(400);
    check(`LCSC_CODE_PQ_FAULT);
    wr(`LCSC_ADDR_CFG_B, 8'h00);
    cyc(4);
    check(`LCSC_CODE_OFF);
    wr(`LCSC_ADDR_CFG_B, 8'h01);
    cyc(4);
    check(`LCSC_CODE_PREQ);
    wr(`LCSC_ADDR_CFG_E, 8'h40);
    sn.battery_node_below_pq = 1'b0;
    put();
    check(`LCSC_CODE_CC);
    cyc(FC_CYC - 200);
    check(`LCSC_CODE_CC);
    cyc(400);
    check(`LCSC_CODE_FC_FAULT);
    sn.input_valid = 1'b0;
    put();
    check(`LCSC_CODE_OFF);
    sn.input_valid = 1'b1;
    put();
    check(`LCSC_CODE_CC);
    wr(`LCSC_ADDR_CFG_B, 8'h00);
    cyc(4);
    check(`LCSC_CODE_OFF);
    wr(`LCSC_ADDR_MASK, 8'h00);
    wr(`LCSC_ADDR_IRQ, 8'hff);
    sn.min_sysv_loop_active = 1'b1;
    sn.die_temp_loop_active = 1'b1;
    put();
    wr(`LCSC_ADDR_STAT_A, 8'h00);
    rd_chk(`LCSC_ADDR_STAT_A, 8'h03);
    rd_chk(`LCSC_ADDR_IRQ, 8'h03);
    cmp_pin({31'h0, irq_o}, 32'h0);
    wr(`LCSC_ADDR_MASK, 8'h03);
    cyc(2);
    cmp_pin({31'h0, irq_o}, 32'h1);
    wr(`LCSC_ADDR_IRQ, 8'h03);
    sn.min_sysv_loop_active = 1'b0;
    put();
    rd_chk(`LCSC_ADDR_IRQ, 8'h01);
    results();
  end
endmodule
